// ===== common/tpw_pkg.sv
// Constants and types shared by the timer PWM and single-pulse block.
//==========================================================================
// Behaviour
// - Clear-select high: A sets period, B sets duty on pin B.
// - Edge PWM, clear-select low: period is field times 128, zero gives 1024.
// - Clear-select low: A and B give independent duties on pins A and B.
// - Alignment field value 11 selects centre alignment, else edge.
// - Edge alignment: all outputs rise together when counter resets to zero.
// - Edge PWM, clear-select high: period equals compare A, 1 to 1023.
// - Centre PWM doubles period, 2046 for field zero, duty 2*value-1.
// - Centre PWM, clear-select high: period is twice compare A.
// - Centre PWM: period flag rises when counter counts down to zero; code never sets it with clear-select high.
// - Duty value at or above the period keeps output active all period.
// - PWM sets separate flags for comparator A, B and period matches; code sets no period flag with clear-select high.
// - Output-level bit picks polarity; pin-function forces high, low or PWM.
// - Polarity-invert bit inverts the channel waveform.
// - Counting continues while pin-function is 00 or 01.
// - Single pulse: run bit rising starts counter and pulse on pin A.
// - Single pulse: comparator B match starts the pulse on pin B.
// - Single pulse: trigger pin edge sets the run bit automatically.
// - Comparator A match clears run bit; run low ends both pulses.
// - Single pulse: counter resets only on run bit rising edge.
// - Single pulse: A and B matches flag; period field, clear-select unused.
// - Compare values are ten bits, low byte plus two-bit high part.
package tpw_pkg;
	localparam int CNT_W = 11;
	localparam int CMP_W = 10;
	localparam int PER_STEP_SHIFT = 7;
	localparam logic [10:0] PER_FULL = 11'h0_400;
	localparam logic [1:0] MODE_PWM = 2'h0_2;
	localparam logic [1:0] PIN_FORCE_LO = 2'h0_0;
	localparam logic [1:0] PIN_FORCE_HI = 2'h0_1;
	localparam logic [1:0] PIN_PWM = 2'h0_2;
	localparam logic [1:0] PIN_PULSE = 2'h0_3;
	localparam logic [1:0] ALIGN_CENTRE = 2'h0_3;
	// Register offsets of the plain register port.
	localparam logic [3:0] ADDR_CTRL1 = 4'h0;
	localparam logic [3:0] ADDR_CTRL2 = 4'h1;
	localparam logic [3:0] ADDR_AL = 4'h2;
	localparam logic [3:0] ADDR_AH = 4'h3;
	localparam logic [3:0] ADDR_BL = 4'h4;
	localparam logic [3:0] ADDR_BH = 4'h5;
	localparam logic [3:0] ADDR_FLAGS = 4'h6;
	// Field positions in control 1.
	localparam int C1_RUN = 7;
	localparam int C1_PER = 4;
	localparam int C1_CCLR = 3;
	localparam int C1_ALIGN = 1;
	// Field positions in control 1 (channel A) and control 2 (channel B); channel A takes its polarity-invert from control 2 bit 6.
	localparam int CX_MODE = 0;
	localparam int CX_PIN = 2;
	localparam int CX_OLVL = 4;
	localparam int CX_POL = 5;
	// Flag bits; writing one clears a flag.
	localparam int FL_A = 0;
	localparam int FL_B = 1;
	localparam int FL_P = 2;
	localparam logic [7:0] RST_BYTE = 8'h0_0;
	typedef enum logic [0:0] {TPW_UP, TPW_DOWN} tpw_dir_t;
endpackage

// ===== common/tpw_chan_if.sv
// Interface carrying one channel's compare inputs and waveform result.
interface tpw_chan_if;
	logic [9:0] duty;
	logic [1:0] pinFunc;
	logic outLevel;
	logic polInvert;
	logic active;
	logic pin;
	modport core (output duty, output pinFunc, output outLevel,
		output polInvert, output active, input pin);
	modport chan (input duty, input pinFunc, input outLevel,
		input polInvert, input active, output pin);
endinterface

// ===== hw/tpw_pin_drv.sv
// Output stage of one channel: polarity and pin forcing.
module tpw_pin_drv (
	input wire logic sys_clk,
	input wire logic srst,
	tpw_chan_if.chan ch
);
	typedef struct packed {
		logic pin;
	} tpw_drv_t;
	tpw_drv_t st;
	tpw_drv_t next_st;

	//==================================================================
	// Pin selection.
	always_comb begin
		next_st = st;
		case (ch.pinFunc)
			tpw_pkg::PIN_FORCE_LO: next_st.pin = 1'b0;
			tpw_pkg::PIN_FORCE_HI: next_st.pin = 1'b1;
			default: next_st.pin = (ch.active ~^ ch.outLevel) ^ ch.polInvert;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ch.pin = st.pin;
endmodule // tpw_pin_drv

// ===== hw/tpw_timer.sv
// Timer PWM and single-pulse generator with register port.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module tpw_timer (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic external_trigger_pin,
	output logic output_pin_a,
	output logic output_pin_b,
	output logic match_a_flag,
	output logic match_b_flag,
	output logic period_match_flag
);
	typedef struct packed {
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [9:0] cmpA;
		logic [9:0] cmpB;
		logic [10:0] cnt;
		tpw_pkg::tpw_dir_t dir;
		logic runPrev;
		logic trigPrev;
		logic actA;
		logic actB;
		logic flagA;
		logic flagB;
		logic flagP;
		logic [7:0] rdata;
	} tpw_state_t;
	tpw_state_t st;
	tpw_state_t next_st;

	tpw_chan_if chA ();
	tpw_chan_if chB ();

	logic run;
	logic cclr;
	logic centre;
	logic pulseMode;
	logic [2:0] perField;
	logic [10:0] perEdge;
	logic [10:0] halfPer;
	logic [10:0] dutyA;
	logic [10:0] dutyB;
	logic hitA;
	logic hitB;
	logic hitP;
	logic wrFlags;

	//==================================================================
	// Mode decoding.
	always_comb begin
		run = st.ctl1[tpw_pkg::C1_RUN];
		cclr = st.ctl1[tpw_pkg::C1_CCLR];
		centre = st.ctl1[tpw_pkg::C1_ALIGN +: 2] == tpw_pkg::ALIGN_CENTRE;
		perField = st.ctl1[tpw_pkg::C1_PER +: 3];
		pulseMode = st.ctl1[tpw_pkg::CX_PIN +: 2] == tpw_pkg::PIN_PULSE
			&& st.ctl1[tpw_pkg::CX_MODE +: 2] == tpw_pkg::MODE_PWM;
		// Period from field in 128 steps, zero meaning 1024.
		perEdge = (perField == 3'h0) ? tpw_pkg::PER_FULL
			: 11'({perField, 7'h0_0});
		// Turning point of the counter: half period in centre alignment, whole period (wrap point) in edge alignment.
		if (cclr) begin
			halfPer = {1'b0, st.cmpA};
		end else if (centre && perField == 3'h0) begin
			halfPer = 11'h3_FF;
		end else begin
			halfPer = perEdge;
		end
		dutyA = {1'b0, st.cmpA};
		dutyB = {1'b0, st.cmpB};
	end

	//==================================================================
	// Counter, comparators, single pulse and register port.
	always_comb begin
		next_st = st;
		hitA = 1'b0;
		hitB = 1'b0;
		hitP = 1'b0;
		wrFlags = regWr && regAddr == tpw_pkg::ADDR_FLAGS;
		next_st.trigPrev = external_trigger_pin;
		next_st.runPrev = run;
		if (pulseMode) begin
			if (run && !st.runPrev) begin
				next_st.cnt = '0;
				next_st.actA = 1'b1;
				next_st.actB = 1'b0;
			end else if (run) begin
				next_st.cnt = st.cnt + 11'h0_01;
				if (st.cnt + 11'h0_01 == dutyB) begin
					hitB = 1'b1;
					next_st.actB = 1'b1;
				end
				if (st.cnt + 11'h0_01 == dutyA) begin
					hitA = 1'b1;
					next_st.ctl1[tpw_pkg::C1_RUN] = 1'b0;
					next_st.actA = 1'b0;
					next_st.actB = 1'b0;
				end
			end else begin
				next_st.actA = 1'b0;
				next_st.actB = 1'b0;
			end
			if (external_trigger_pin && !st.trigPrev) begin
				next_st.ctl1[tpw_pkg::C1_RUN] = 1'b1;
			end
		end else if (run) begin
			// Counting runs whatever the pin-function setting.
			if (!centre) begin
				if (st.cnt + 11'h0_01 >= halfPer) begin
					next_st.cnt = '0;
					hitP = !cclr;
				end else begin
					next_st.cnt = st.cnt + 11'h0_01;
				end
				if (st.cnt + 11'h0_01 == dutyA) begin
					hitA = 1'b1;
				end
				if (st.cnt + 11'h0_01 == dutyB) begin
					hitB = 1'b1;
				end
				// Active from reset to zero until the duty count.
				next_st.actA = next_st.cnt < dutyA || dutyA >= halfPer;
				next_st.actB = next_st.cnt < dutyB || dutyB >= halfPer;
			end else begin
				if (st.dir == tpw_pkg::TPW_UP) begin
					if (st.cnt + 11'h0_01 >= halfPer) begin
						next_st.dir = tpw_pkg::TPW_DOWN;
					end
					next_st.cnt = st.cnt + 11'h0_01;
				end else begin
					next_st.cnt = st.cnt - 11'h0_01;
					if (st.cnt == 11'h0_01) begin
						next_st.dir = tpw_pkg::TPW_UP;
						hitP = !cclr;
					end
				end
				hitA = next_st.cnt == dutyA;
				hitB = next_st.cnt == dutyB;
				// Active below the compare value on both slopes gives 2*value-1.
				next_st.actA = next_st.cnt < dutyA || dutyA >= halfPer;
				next_st.actB = next_st.cnt < dutyB || dutyB >= halfPer;
			end
		end else begin
			next_st.cnt = '0;
			next_st.dir = tpw_pkg::TPW_UP;
			next_st.actA = 1'b0;
			next_st.actB = 1'b0;
		end
		// Counter-clear select high leaves pin A without a waveform.
		if (!pulseMode && cclr) begin
			next_st.actA = 1'b0;
		end
		if (pulseMode) begin
			hitP = 1'b0;
		end
		// Register writes; hardware flag set wins over the clear.
		if (regWr) begin
			case (regAddr)
				tpw_pkg::ADDR_CTRL1: next_st.ctl1 = regWdata;
				tpw_pkg::ADDR_CTRL2: next_st.ctl2 = regWdata;
				tpw_pkg::ADDR_AL: next_st.cmpA[7:0] = regWdata;
				tpw_pkg::ADDR_AH: next_st.cmpA[9:8] = regWdata[1:0];
				tpw_pkg::ADDR_BL: next_st.cmpB[7:0] = regWdata;
				tpw_pkg::ADDR_BH: next_st.cmpB[9:8] = regWdata[1:0];
				default: next_st.rdata = st.rdata;
			endcase
		end
		next_st.flagA = (st.flagA && !(wrFlags && regWdata[tpw_pkg::FL_A]))
			|| hitA;
		next_st.flagB = (st.flagB && !(wrFlags && regWdata[tpw_pkg::FL_B]))
			|| hitB;
		next_st.flagP = (st.flagP && !(wrFlags && regWdata[tpw_pkg::FL_P]))
			|| hitP;
		next_st.rdata = tpw_pkg::RST_BYTE;
		if (regRd) begin
			case (regAddr)
				tpw_pkg::ADDR_CTRL1: next_st.rdata = st.ctl1;
				tpw_pkg::ADDR_CTRL2: next_st.rdata = st.ctl2;
				tpw_pkg::ADDR_AL: next_st.rdata = st.cmpA[7:0];
				tpw_pkg::ADDR_AH: next_st.rdata = {6'h0_0, st.cmpA[9:8]};
				tpw_pkg::ADDR_BL: next_st.rdata = st.cmpB[7:0];
				tpw_pkg::ADDR_BH: next_st.rdata = {6'h0_0, st.cmpB[9:8]};
				tpw_pkg::ADDR_FLAGS: next_st.rdata = {5'h0_0, st.flagP,
					st.flagB, st.flagA};
				default: next_st.rdata = tpw_pkg::RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	//==================================================================
	// Channel output stages.
	always_comb begin
		chA.duty = st.cmpA;
		chA.pinFunc = st.ctl1[tpw_pkg::CX_PIN +: 2];
		chA.outLevel = st.ctl1[tpw_pkg::CX_OLVL];
		chA.polInvert = st.ctl2[6];
		chA.active = st.actA;
		chB.duty = st.cmpB;
		chB.pinFunc = st.ctl2[tpw_pkg::CX_PIN +: 2];
		chB.outLevel = st.ctl2[tpw_pkg::CX_OLVL];
		chB.polInvert = st.ctl2[tpw_pkg::CX_POL];
		chB.active = st.actB;
	end

	tpw_pin_drv uDrvA (.sys_clk(sys_clk), .srst(srst), .ch(chA.chan));
	tpw_pin_drv uDrvB (.sys_clk(sys_clk), .srst(srst), .ch(chB.chan));

	assign output_pin_a = chA.pin;
	assign output_pin_b = chB.pin;
	assign regRdata = st.rdata;
	assign match_a_flag = st.flagA;
	assign match_b_flag = st.flagB;
	assign period_match_flag = st.flagP;
endmodule // tpw_timer

// ===== sim/tpw_timer_asserts.sv
// Port checker of the timer PWM and single-pulse block.
//==========
// Checks on the top module's ports.
module tpw_timer_asserts (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic external_trigger_pin,
	input wire logic output_pin_a,
	input wire logic output_pin_b,
	input wire logic match_a_flag,
	input wire logic match_b_flag,
	input wire logic period_match_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctlOne;
	logic [7:0] ctlTwo;
	logic pulse;
	logic forceLo;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctlOne <= 8'h00;
			ctlTwo <= 8'h00;
		end else if (regWr && regAddr == 4'h0) begin
			ctlOne <= regWdata;
		end else if (regWr && regAddr == 4'h1) begin
			ctlTwo <= regWdata;
		end
	end
	assign pulse = ctlOne[4:0] == 5'h1E && ctlTwo[6:0] == 7'h1E;
	assign forceLo = ctlOne[3:0] == 4'h2;
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property (regRd && regAddr > 4'h6 |=> !regRdata)
		else $error("unmapped read not zero");
	high_part_a: assert property ((regRd && (regAddr == 4'h3
		|| regAddr == 4'h5)) |=> regRdata[7:2] == 6'h00)
		else $error("high part wider than two bits");
	flag_hold_a: assert property (match_a_flag && !(regWr
		&& regAddr == 4'h6 && regWdata[0]) |=> match_a_flag)
		else $error("flag dropped without clear");
	pulse_b_inside_a: assert property (pulse && $rose(output_pin_b)
		|-> output_pin_a)
		else $error("pin b pulse outside pin a pulse");
	pulse_end_a: assert property (pulse && $rose(match_a_flag)
		|-> ##[0:3] !output_pin_a && !output_pin_b)
		else $error("pulse not ended by match a");
	trig_start_a: assert property (pulse && !output_pin_a
		&& $rose(external_trigger_pin) |-> ##[1:4] output_pin_a)
		else $error("trigger did not start pulse");
	force_low_a: assert property (forceLo && $past(forceLo, 3)
		|-> !output_pin_a)
		else $error("forced low pin not low");
	cover property (pulse && $rose(output_pin_a));
	cover property ($rose(period_match_flag));
	cover property ($rose(match_b_flag));
endmodule // tpw_timer_asserts

bind tpw_timer tpw_timer_asserts chk (.*);

// ===== sim/tpw_load_model.sv
// Load model that measures high time and period on one pin.
module tpw_load_model (
	input wire logic sys_clk,
	input wire logic pin,
	output int highLen,
	output int perLen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last = 1'b0;
	int hiCnt = 0;
	int perCnt = 0;
	initial highLen = 0;
	initial perLen = 0;
	always @(posedge sys_clk) begin
		last <= pin;
		perCnt <= (pin && !last) ? 1 : perCnt + 1;
		hiCnt <= pin ? hiCnt + 1 : 0;
		if (pin && !last) perLen <= perCnt;
		if (!pin && last) highLen <= hiCnt;
	end
endmodule // tpw_load_model

// ===== sim/testbench.sv
// Self-checking bench of the timer PWM and single-pulse block.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk;
	logic srst;
	logic [3:0] regAddr;
	logic [7:0] regWdata;
	logic regWr;
	logic regRd;
	logic [7:0] regRdata;
	logic external_trigger_pin;
	logic output_pin_a;
	logic output_pin_b;
	logic match_a_flag;
	logic match_b_flag;
	logic period_match_flag;
	int highA;
	int highB;
	int perB;
	int numErrors = 0;
	int checks = 0;
	int cycles = 0;
	tpw_timer uut (.*);
	tpw_load_model loadA (.sys_clk(sys_clk), .pin(output_pin_a),
		.highLen(highA), .perLen());
	tpw_load_model loadB (.sys_clk(sys_clk), .pin(output_pin_b),
		.highLen(highB), .perLen(perB));
	//==========
	// Clock, bus tasks and closing report.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			numErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] got;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 got = regRdata;
		@(posedge sys_clk);
		chk(got, exp);
	endtask
	task automatic setAB(input logic [9:0] a, input logic [9:0] b);
		wr(4'h2, a[7:0]);
		wr(4'h3, {6'h00, a[9:8]});
		wr(4'h4, b[7:0]);
		wr(4'h5, {6'h00, b[9:8]});
	endtask
	task automatic results;
		$display("checks=%0d numErrors=%0d", checks, numErrors);
		if (numErrors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 9000) begin
			numErrors++;
			results();
		end
	end
	//==========
	// Scenarios.
	task automatic t_regs;
		for (int i = 7; i < 16; i++) begin
			wr(4'(i), 8'hFF);
			rdc(4'(i), 8'h00);
		end
		rdc(4'h6, 8'h00);
		wr(4'h5, 8'hFF);
		rdc(4'h5, 8'h03);
		$display("register test done");
	endtask
	task automatic t_fine;
		int lows;
		lows = 0;
		setAB(10'h014, 10'h005);
		wr(4'h1, 8'h1A);
		wr(4'h0, 8'h9A);
		run(70);
		chk(perB, 20);
		chk(highB, 5);
		wr(4'h1, 8'h3A);
		run(50);
		chk(highB, 15);
		wr(4'h1, 8'h1A);
		setAB(10'h014, 10'h019);
		run(30);
		repeat (40) begin
			@(posedge sys_clk);
			if (output_pin_b !== 1'b1) lows++;
		end
		chk(lows, 0);
		wr(4'h0, 8'h1A);
		$display("fine period test done");
	endtask
	task automatic t_coarse;
		setAB(10'h010, 10'h020);
		wr(4'h0, 8'h92);
		run(300);
		chk(perB, 128);
		chk(highB, 32);
		chk(output_pin_a, 1'b0);
		wr(4'h0, 8'h82);
		run(2100);
		chk(perB, 1024);
		rdc(4'h6, 8'h07);
		wr(4'h0, 8'h02);
		wr(4'h6, 8'h07);
		rdc(4'h6, 8'h00);
		$display("coarse period test done");
	endtask
	task automatic t_centre;
		setAB(10'h010, 10'h00A);
		wr(4'h0, 8'h96);
		run(600);
		chk(perB, 256);
		chk(highB, 19);
		chk(output_pin_a, 1'b1);
		rdc(4'h6, 8'h07);
		wr(4'h0, 8'h16);
		$display("centre test done");
	endtask
	task automatic t_pulse;
		setAB(10'h028, 10'h00A);
		wr(4'h1, 8'h1E);
		wr(4'h0, 8'h1E);
		wr(4'h6, 8'h07);
		wr(4'h0, 8'h9E);
		run(60);
		chk(highA, 40);
		chk(highB, 30);
		rdc(4'h0, 8'h1E);
		rdc(4'h6, 8'h03);
		external_trigger_pin <= 1'b1;
		run(5);
		rdc(4'h0, 8'h9E);
		run(60);
		chk(highA, 40);
		rdc(4'h0, 8'h1E);
		external_trigger_pin <= 1'b0;
		$display("single pulse test done");
	endtask
	initial begin
		srst = 1'b1;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		external_trigger_pin = 1'b0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs();
		t_fine();
		t_coarse();
		t_centre();
		t_pulse();
		results();
	end
endmodule // testbench
